// [design/psbc_addr.sv]
// Burst address sequencer with wrap and linear modes
`timescale 1ns/100ps
`include "psbc_defines.svh"
module psbc_addr #(
    parameter int AW = 23,
    parameter int ROW_W = 7
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    psbc_cfg_if.adr cfg,
    output logic [AW-1:0] addr_o,
    output logic eor_o
);
    typedef struct packed {
        logic [AW-1:0] addr;
    } psbc_adr_s_t;
    psbc_adr_s_t s_r;
    psbc_adr_s_t s_nxt;
    logic [AW-1:0] mask;
    logic wrap_on;
    if (ROW_W < 5 || ROW_W >= AW || AW > 32) begin : g_chk
        $error("AW or ROW_W out of range");
    end
    always_comb begin
        case (cfg.len)
            `PSBC_LEN_4: mask = AW'(`PSBC_MASK_4);
            `PSBC_LEN_8: mask = AW'(`PSBC_MASK_8);
            `PSBC_LEN_16: mask = AW'(`PSBC_MASK_16);
            `PSBC_LEN_32: mask = AW'(`PSBC_MASK_32);
            default: mask = '0;
        endcase
        // Reserved lengths fall back to continuous
        wrap_on = !cfg.wrap_off && (mask != '0);
        s_nxt = s_r;
        if (cfg.start) begin
            s_nxt.addr = cfg.start_addr;
        end else if (cfg.step) begin
            if (wrap_on) begin
                s_nxt.addr = (s_r.addr & ~mask) | ((s_r.addr + 1'b1) & mask);
            end else begin
                s_nxt.addr = s_r.addr + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign addr_o = s_r.addr;
    assign eor_o = !wrap_on && (&s_r.addr[ROW_W-1:0]);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_wrap_eight:
        assert property (cfg.step && !cfg.start && !cfg.wrap_off && cfg.len == `PSBC_LEN_8
            && s_r.addr[2:0] == 3'h7 |=> s_r.addr[2:0] == 3'h0 && s_r.addr[AW-1:3] == $past(s_r.addr[AW-1:3]))
        else $error("8-word wrap left its group");
    a_linear_step:
        assert property (cfg.step && !cfg.start && cfg.wrap_off |=> s_r.addr == AW'($past(s_r.addr) + 1'b1))
        else $error("linear burst did not increment");
    a_start_load:
        assert property (cfg.start |=> s_r.addr == $past(cfg.start_addr))
        else $error("new burst did not load its address");
    c_wrap: cover property (cfg.step && wrap_on && (s_r.addr & mask) == mask);
endmodule : psbc_addr

// [design/psbc_lat.sv]
// Initial latency counter with refresh extension and wait timing
`timescale 1ns/100ps
`include "psbc_defines.svh"
module psbc_lat #(
    parameter int REFRESH_WAIT = 4
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    psbc_cfg_if.lat cfg,
    output logic first_o,
    output logic wait_act_o
);
    psbc_pkg::psbc_lat_s_t s_r;
    psbc_pkg::psbc_lat_s_t s_nxt;
    logic [4:0] load;
    if (REFRESH_WAIT < 0 || REFRESH_WAIT > 24) begin : g_chk
        $error("REFRESH_WAIT out of range");
    end
    always_comb begin
        load = {2'h0, cfg.lat_code};
        if (!cfg.fixed && cfg.is_rd && cfg.refresh) begin
            load = 5'(cfg.lat_code + REFRESH_WAIT);
        end
        // Reserved code 0 would wrap the counter and take 32 ticks
        if (load < `PSBC_LAT_LAST) begin
            load = `PSBC_LAT_LAST;
        end
        s_nxt = s_r;
        if (cfg.stop) begin
            s_nxt = '0;
        end else if (cfg.start) begin
            s_nxt.run = 1'b1;
            s_nxt.cnt = load;
        end else if (s_r.run && cfg.tick) begin
            s_nxt.cnt = s_r.cnt - 5'h01;
            s_nxt.run = (s_r.cnt != `PSBC_LAT_LAST);
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign first_o = s_r.run & cfg.tick & ~cfg.start & ~cfg.stop & (s_r.cnt == `PSBC_LAT_LAST);
    // Early mode drops wait for the last latency cycle, one cycle before normal mode
    assign wait_act_o = s_r.run & (s_r.cnt > (cfg.early ? `PSBC_LAT_LAST : 5'h00));

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_fixed_exact:
        assert property (cfg.start && !cfg.stop && cfg.fixed && cfg.lat_code >= `PSBC_LAT_C2
            |=> s_r.run && s_r.cnt == {2'h0, $past(cfg.lat_code)})
        else $error("fixed latency not loaded exactly");
    a_write_no_extra:
        assert property (cfg.start && !cfg.stop && !cfg.is_rd && cfg.lat_code >= `PSBC_LAT_C2
            |=> s_r.cnt == {2'h0, $past(cfg.lat_code)})
        else $error("write latency extended");
    a_refresh_extends:
        assert property (cfg.start && !cfg.stop && !cfg.fixed && cfg.is_rd && cfg.refresh
            && cfg.lat_code >= `PSBC_LAT_C2 |=> s_r.cnt == 5'($past(cfg.lat_code) + REFRESH_WAIT))
        else $error("refresh collision did not add wait cycles");
    a_early_drop:
        assert property (s_r.run && s_r.cnt == `PSBC_LAT_LAST |-> wait_act_o == !cfg.early)
        else $error("wait timing does not follow configuration");
    c_refresh: cover property (cfg.start && cfg.is_rd && cfg.refresh && !cfg.fixed);
endmodule : psbc_lat

// [design/psbc_top.sv]
// Pseudo-static RAM bus configuration, protocol detection and burst timing
`timescale 1ns/100ps
`include "psbc_defines.svh"
module psbc_top #(
    parameter int AW = 23,
    parameter int ROW_W = 7,
    parameter int REFRESH_WAIT = 4,
    parameter int LINK_MHZ = 66
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic mem_clk_i,
    input wire logic ce_n_i,
    input wire logic adv_n_i,
    input wire logic we_n_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic refresh_busy_i,
    output logic wait_o,
    output logic [AW-1:0] burst_addr_o,
    output logic rd_valid_o,
    output logic wr_valid_o,
    output logic sync_write_o,
    output logic async_acc_o
);
    localparam psbc_pkg::psbc_top_s_t TOP_RST = '{
        bus_config_register: `PSBC_BCR_RST,
        st: psbc_pkg::st_idle,
        ce_high: 1'b1,
        adv_prev: 1'b1,
        default: '0
    };

    psbc_pkg::psbc_top_s_t s_r;
    psbc_pkg::psbc_top_s_t s_nxt;
    logic clk_rise;
    logic mode_async;
    logic cmd_sel;
    logic sync_cmd;
    logic adv_rel;
    logic async_go;
    logic async_wr;
    logic new_acc;
    logic new_sync;
    logic req;
    logic blk;
    logic w_go;
    logic cfg_err;
    logic freq_err;
    logic len_bad;
    logic var_rd;
    logic first;
    logic wait_act;
    logic end_of_row;
    logic [7:0] max_mhz;
    logic [7:0] clr;
    logic [15:0] bcr_w;
    logic [31:0] stat_w;
    logic [31:0] rd_mux;
    logic [AW-1:0] burst_addr;

    psbc_cfg_if #(.AW(AW)) cfg ();

    if (AW > 32 || LINK_MHZ < 1) begin : g_chk
        $error("AW or LINK_MHZ out of range");
    end

    // Highest clock the programmed latency code allows; zero marks a reserved code
    function automatic logic [7:0] psbc_max_mhz(input logic fixed, input logic [2:0] code);
        logic [7:0] m;
        m = 8'h00;
        if (fixed) begin
            case (code)
                `PSBC_LAT_C2: m = `PSBC_MHZ_F2;
                `PSBC_LAT_C3: m = `PSBC_MHZ_F3;
                `PSBC_LAT_C4: m = `PSBC_MHZ_F4;
                `PSBC_LAT_C5: m = `PSBC_MHZ_F5;
                `PSBC_LAT_C6: m = `PSBC_MHZ_F6;
                default: m = 8'h00;
            endcase
        end else begin
            case (code)
                `PSBC_LAT_C2: m = `PSBC_MHZ_V2;
                `PSBC_LAT_C3: m = `PSBC_MHZ_V3;
                default: m = 8'h00;
            endcase
        end
        return m;
    endfunction : psbc_max_mhz

    psbc_lat #(
        .REFRESH_WAIT(REFRESH_WAIT)
    ) u_lat (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .cfg(cfg.lat),
        .first_o(first),
        .wait_act_o(wait_act)
    );

    psbc_addr #(
        .AW(AW),
        .ROW_W(ROW_W)
    ) u_addr (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .cfg(cfg.adr),
        .addr_o(burst_addr),
        .eor_o(end_of_row)
    );

    assign cfg.fixed = s_r.bus_config_register[`PSBC_B_FIXED];
    assign cfg.lat_code = s_r.bus_config_register[`PSBC_F_LAT];
    assign cfg.early = s_r.bus_config_register[`PSBC_B_WCFG];
    assign cfg.wrap_off = s_r.bus_config_register[`PSBC_B_WRAP];
    assign cfg.len = s_r.bus_config_register[`PSBC_F_LEN];
    assign cfg.start = sync_cmd & (s_r.st != psbc_pkg::st_async);
    assign cfg.tick = clk_rise;
    assign cfg.stop = ce_n_i;
    assign cfg.is_rd = we_n_i;
    assign cfg.refresh = refresh_busy_i;
    assign cfg.step = clk_rise & ~ce_n_i & ~sync_cmd & (s_r.st == psbc_pkg::st_data);
    assign cfg.start_addr = addr_i;

    always_comb begin
        s_nxt = s_r;
        s_nxt.clk_prev = mem_clk_i;
        s_nxt.adv_prev = adv_n_i;
        s_nxt.rd_v = 1'b0;
        s_nxt.wr_v = 1'b0;
        s_nxt.ack = 1'b0;

        // Clock pin is sampled; its rising edge is one link cycle
        clk_rise = mem_clk_i & ~s_r.clk_prev;
        mode_async = s_r.bus_config_register[`PSBC_B_MODE];
        cmd_sel = ~ce_n_i & ~adv_n_i;
        sync_cmd = cmd_sel & clk_rise & ~mode_async;
        adv_rel = ~s_r.adv_prev & adv_n_i;
        async_go = cmd_sel & mode_async & (s_r.st == psbc_pkg::st_idle);
        // No edge seen while address valid was low: asynchronous write
        async_wr = adv_rel & ~s_r.adv_edge & ~ce_n_i & ~we_n_i & ~mode_async
            & (s_r.st == psbc_pkg::st_idle);
        s_nxt.adv_edge = ~adv_n_i & (s_r.adv_edge | clk_rise);

        new_sync = cfg.start;
        new_acc = new_sync | async_go | async_wr;
        s_nxt.ce_high = s_r.ce_high | ce_n_i;

        // Protocol change without chip enable going high between accesses
        clr = 8'h00;
        w_go = avs_write_i & s_r.ack;
        if (w_go && avs_address_i == `PSBC_OFF_STAT && avs_byteenable_i[0]) begin
            clr = avs_writedata_i[7:0];
        end
        s_nxt.seq_err = s_r.seq_err & ~clr[`PSBC_S_SEQ];
        s_nxt.eor_err = s_r.eor_err & ~clr[`PSBC_S_EOR];
        if (new_acc) begin
            s_nxt.ce_high = 1'b0;
            s_nxt.sync_last = new_sync;
            if (!s_r.ce_high && (new_sync != s_r.sync_last)) begin
                s_nxt.seq_err = 1'b1;
            end
        end
        // Linear burst stepping across a row end is a controller fault
        if (cfg.step && end_of_row) begin
            s_nxt.eor_err = 1'b1;
        end

        case (s_r.st)
            psbc_pkg::st_idle: begin
                if (new_sync) begin
                    s_nxt.st = psbc_pkg::st_lat;
                    s_nxt.is_wr = ~we_n_i;
                    s_nxt.sync_wr = ~we_n_i | s_r.sync_wr & we_n_i;
                end else if (async_go || async_wr) begin
                    s_nxt.st = psbc_pkg::st_async;
                    s_nxt.is_wr = ~we_n_i;
                    if (async_wr) begin
                        s_nxt.sync_wr = 1'b0;
                    end
                end
            end
            psbc_pkg::st_lat: begin
                if (ce_n_i) begin
                    s_nxt.st = psbc_pkg::st_idle;
                end else if (new_sync) begin
                    // Address valid low in the latency phase is taken as a new command
                    s_nxt.is_wr = ~we_n_i;
                    if (!we_n_i) begin
                        s_nxt.sync_wr = 1'b1;
                    end
                end else if (first) begin
                    s_nxt.st = psbc_pkg::st_data;
                    s_nxt.rd_v = ~s_r.is_wr;
                    s_nxt.wr_v = s_r.is_wr;
                end
            end
            psbc_pkg::st_data: begin
                if (ce_n_i) begin
                    s_nxt.st = psbc_pkg::st_idle;
                end else if (new_sync) begin
                    s_nxt.st = psbc_pkg::st_lat;
                    s_nxt.is_wr = ~we_n_i;
                    if (!we_n_i) begin
                        s_nxt.sync_wr = 1'b1;
                    end
                end else if (clk_rise) begin
                    // Bursts never stop on their own after the programmed length
                    s_nxt.rd_v = ~s_r.is_wr;
                    s_nxt.wr_v = s_r.is_wr;
                end
            end
            psbc_pkg::st_async: begin
                if (ce_n_i) begin
                    s_nxt.st = psbc_pkg::st_idle;
                end
            end
            default: begin
                s_nxt.st = psbc_pkg::st_idle;
            end
        endcase

        // Wait only speaks for variable-latency synchronous reads
        var_rd = ~s_r.bus_config_register[`PSBC_B_FIXED] & ~s_r.is_wr & (s_r.st == psbc_pkg::st_lat) & wait_act;
        s_nxt.wait_q = var_rd ? s_r.bus_config_register[`PSBC_B_WPOL] : ~s_r.bus_config_register[`PSBC_B_WPOL];

        max_mhz = psbc_max_mhz(s_r.bus_config_register[`PSBC_B_FIXED], s_r.bus_config_register[`PSBC_F_LAT]);
        len_bad = ~(s_r.bus_config_register[`PSBC_F_LEN] inside {`PSBC_LEN_4, `PSBC_LEN_8, `PSBC_LEN_16,
            `PSBC_LEN_32, `PSBC_LEN_CONT});
        cfg_err = (max_mhz == 8'h00) | len_bad;
        freq_err = (max_mhz != 8'h00) && (LINK_MHZ > int'(max_mhz));

        stat_w = 32'h0;
        stat_w[`PSBC_S_SEQ] = s_r.seq_err;
        stat_w[`PSBC_S_EOR] = s_r.eor_err;
        stat_w[`PSBC_S_CFG] = cfg_err;
        stat_w[`PSBC_S_FREQ] = freq_err;
        stat_w[`PSBC_S_SWR] = s_r.sync_wr;
        stat_w[`PSBC_S_BUSY] = (s_r.st != psbc_pkg::st_idle);
        stat_w[`PSBC_S_WAIT] = var_rd;
        stat_w[`PSBC_F_STATE] = s_r.st;
        case (avs_address_i)
            `PSBC_OFF_BCR: rd_mux = {16'h0, s_r.bus_config_register};
            `PSBC_OFF_STAT: rd_mux = stat_w;
            `PSBC_OFF_ADDR: rd_mux = 32'(burst_addr);
            default: rd_mux = 32'h0;
        endcase

        // Configuration may change only while the bus side is idle
        req = avs_read_i | avs_write_i;
        blk = avs_write_i & (avs_address_i == `PSBC_OFF_BCR) & (s_r.st != psbc_pkg::st_idle);
        avs_waitrequest_o = req & ~s_r.ack;
        if (req && !s_r.ack && !blk) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = avs_read_i ? rd_mux : 32'h0;
        end
        bcr_w = s_r.bus_config_register;
        for (int i = 0; i < 2; i++) begin
            if (avs_byteenable_i[i]) begin
                bcr_w[i*8 +: 8] = avs_writedata_i[i*8 +: 8];
            end
        end
        if (w_go && avs_address_i == `PSBC_OFF_BCR) begin
            s_nxt.bus_config_register = bcr_w & `PSBC_BCR_WMASK;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            s_r <= TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata_o = s_r.rdata;
    assign wait_o = s_r.wait_q;
    assign burst_addr_o = burst_addr;
    assign rd_valid_o = s_r.rd_v;
    assign wr_valid_o = s_r.wr_v;
    assign sync_write_o = s_r.sync_wr;
    assign async_acc_o = (s_r.st == psbc_pkg::st_async);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_async_only:
        assert property (s_r.bus_config_register[`PSBC_B_MODE] && cmd_sel && s_r.st == psbc_pkg::st_idle
            |=> s_r.st == psbc_pkg::st_async)
        else $error("asynchronous mode took a synchronous path");
    a_sync_write:
        assert property (!s_r.bus_config_register[`PSBC_B_MODE] && cmd_sel && clk_rise && !we_n_i
            && s_r.st == psbc_pkg::st_idle |=> s_r.st == psbc_pkg::st_lat && s_r.sync_wr)
        else $error("synchronous write not detected");
    a_nor_write:
        assert property (async_wr |=> s_r.st == psbc_pkg::st_async && !s_r.sync_wr)
        else $error("asynchronous write not detected");
    a_seq_flag:
        assert property (new_acc && !s_r.ce_high && new_sync != s_r.sync_last |=> s_r.seq_err)
        else $error("protocol switch without chip enable high not flagged");
    a_wait_idle:
        assert property (s_r.st != psbc_pkg::st_lat |=> wait_o == !$past(s_r.bus_config_register[`PSBC_B_WPOL]))
        else $error("wait active outside latency");
    a_burst_runs:
        assert property (s_r.st == psbc_pkg::st_data && !ce_n_i && !sync_cmd
            |=> s_r.st == psbc_pkg::st_data)
        else $error("burst stopped by itself");
    a_ce_ends:
        assert property (s_r.st == psbc_pkg::st_data && ce_n_i
            |=> s_r.st == psbc_pkg::st_idle && !rd_valid_o && !wr_valid_o)
        else $error("chip enable high did not end burst");
    a_bcr_default:
        assert property ($rose(nrst_i) |-> s_r.bus_config_register == `PSBC_BCR_RST && s_r.st == psbc_pkg::st_idle)
        else $error("configuration default wrong after reset");
    a_bcr_busy:
        assert property (avs_write_i && avs_address_i == `PSBC_OFF_BCR
            && s_r.st != psbc_pkg::st_idle && !s_r.ack |=> avs_waitrequest_o)
        else $error("configuration write taken during access");
    c_sync_read: cover property (s_r.st == psbc_pkg::st_lat && s_r.is_wr == 1'b0 ##1 rd_valid_o);
    c_nor_write: cover property (async_wr);
    c_bcr_write: cover property (w_go && avs_address_i == `PSBC_OFF_BCR);
endmodule : psbc_top

// [include/psbc_cfg_if.sv]
// Configuration and burst timing signals shared inside the block
`timescale 1ns/100ps
interface psbc_cfg_if #(parameter int AW = 23);
    logic fixed;
    logic [2:0] lat_code;
    logic early;
    logic wrap_off;
    logic [2:0] len;
    logic start;
    logic tick;
    logic stop;
    logic is_rd;
    logic refresh;
    logic step;
    logic [AW-1:0] start_addr;
    modport ctl (output fixed, lat_code, early, wrap_off, len, start, tick, stop, is_rd, refresh, step, start_addr);
    modport lat (input fixed, lat_code, early, start, tick, stop, is_rd, refresh);
    modport adr (input wrap_off, len, start, step, start_addr);
endinterface : psbc_cfg_if

// [include/psbc_defines.svh]
// Register map, field positions, reset values and codes of the burst bus configuration block
// What this block does
// - Operating-mode bit set: reads and writes use the asynchronous protocol.
// - Mode bit clear: clock edge during address valid makes a synchronous write.
// - No edge means asynchronous write; controller raises chip enable between protocols.
// - Latency counts clock cycles from burst command to first data word.
// - Fixed latency: first data exactly latency-code cycles after the command.
// - Variable latency: code is the minimum; refresh collision adds read wait cycles.
// - Variable latency never adds wait cycles to burst writes.
// - Variable latency allows codes 2 (66 MHz) and 3 (80 MHz) only.
// - Fixed latency allows codes 2 to 6 at 33/52/66/75/104 MHz.
// - Variable synchronous read: wait at its active level while data invalid.
// - Wait configuration: assert during the delay or one cycle before it.
// - Wrap with 8-word length returns from word 7 to word 0.
// - Wrap and length settings act alike for reads and writes.
// - Wrap bit clear: length sets wrap boundary; set: always continuous.
// - Fixed-length burst runs until chip enable rises or a new burst starts.
// - Wrapping burst cycles its aligned 4, 8, 16 or 32 word block.
// - Operating-mode bit 15: zero synchronous, one asynchronous, reset asynchronous.
// - Length codes 1..4 give 4..32 words, 7 continuous and default.
// - Wait polarity bit 10: zero active low, one active high, default.
// - Wait configuration bit 8: one means one cycle early, default.
`ifndef PSBC_DEFINES_SVH
`define PSBC_DEFINES_SVH
`define PSBC_OFF_BCR 4'h0
`define PSBC_OFF_STAT 4'h4
`define PSBC_OFF_ADDR 4'h8
`define PSBC_BCR_RST 16'h9d1f
`define PSBC_BCR_WMASK 16'hfd3f
`define PSBC_B_MODE 15
`define PSBC_B_FIXED 14
`define PSBC_F_LAT 13:11
`define PSBC_B_WPOL 10
`define PSBC_B_WCFG 8
`define PSBC_B_WRAP 3
`define PSBC_F_LEN 2:0
`define PSBC_LEN_4 3'h1
`define PSBC_LEN_8 3'h2
`define PSBC_LEN_16 3'h3
`define PSBC_LEN_32 3'h4
`define PSBC_LEN_CONT 3'h7
`define PSBC_MASK_4 5'h03
`define PSBC_MASK_8 5'h07
`define PSBC_MASK_16 5'h0f
`define PSBC_MASK_32 5'h1f
`define PSBC_LAT_C2 3'h2
`define PSBC_LAT_C3 3'h3
`define PSBC_LAT_C4 3'h4
`define PSBC_LAT_C5 3'h5
`define PSBC_LAT_C6 3'h6
`define PSBC_LAT_LAST 5'h01
`define PSBC_MHZ_F2 8'h21
`define PSBC_MHZ_F3 8'h34
`define PSBC_MHZ_F4 8'h42
`define PSBC_MHZ_F5 8'h4b
`define PSBC_MHZ_F6 8'h68
`define PSBC_MHZ_V2 8'h42
`define PSBC_MHZ_V3 8'h50
`define PSBC_S_SEQ 0
`define PSBC_S_EOR 1
`define PSBC_S_CFG 2
`define PSBC_S_FREQ 3
`define PSBC_S_SWR 4
`define PSBC_S_BUSY 5
`define PSBC_S_WAIT 6
`define PSBC_F_STATE 11:8
`endif

// [include/psbc_pkg.sv]
// Shared types of the burst bus configuration block
package psbc_pkg;
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_lat = 4'h2,
        st_data = 4'h4,
        st_async = 4'h8
    } psbc_st_t;
    typedef struct packed {
        logic [15:0] bus_config_register;
        psbc_st_t st;
        logic is_wr;
        logic sync_last;
        logic sync_wr;
        logic ce_high;
        logic adv_edge;
        logic adv_prev;
        logic clk_prev;
        logic seq_err;
        logic eor_err;
        logic ack;
        logic [31:0] rdata;
        logic rd_v;
        logic wr_v;
        logic wait_q;
    } psbc_top_s_t;
    typedef struct packed {
        logic run;
        logic [4:0] cnt;
    } psbc_lat_s_t;
endpackage : psbc_pkg

// [sim/psbc_mem_ctl.sv]
// Model of the external controller on the burst bus
`timescale 1ns/100ps
module psbc_mem_ctl (
    input wire logic ref_clk_i,
    output logic mem_clk_o = 1'b0,
    output logic ce_n_o = 1'b1,
    output logic adv_n_o = 1'b1,
    output logic we_n_o = 1'b1,
    output logic [22:0] addr_o = 23'h0
);
    logic run = 1'b0;
    logic [1:0] div = 2'h0;
    // Link clock stands still outside frames
    always @(posedge ref_clk_i) begin
        div <= run ? div + 2'h1 : 2'h0;
        mem_clk_o <= run & div[1];
    end
    task cmd(input logic [22:0] a, input logic w, input logic clk_on);
        @(posedge ref_clk_i);
        ce_n_o <= 1'b0;
        adv_n_o <= 1'b0;
        we_n_o <= ~w;
        addr_o <= a;
        run <= clk_on;
        repeat (6) @(posedge ref_clk_i);
        adv_n_o <= 1'b1;
        addr_o <= ~a;
    endtask : cmd
    task stop();
        @(posedge ref_clk_i);
        ce_n_o <= 1'b1;
        run <= 1'b0;
    endtask : stop
endmodule : psbc_mem_ctl

// [sim/psram_burst_bus_config_tb.sv]
// Self-checking bench of the burst bus configuration block
`timescale 1ns/100ps
module psram_burst_bus_config_tb;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic rfsh = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rq;
    logic [22:0] maddr, baddr;
    logic wq, mclk, ce_n, adv_n, we_n, wt, rv, wv, sw, aa;
    logic mprev = 1'b0;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int rises = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        mprev <= mclk;
        rises <= rises + int'(mclk & ~mprev);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    psbc_mem_ctl M (.ref_clk_i(ref_clk_i), .mem_clk_o(mclk), .ce_n_o(ce_n), .adv_n_o(adv_n), .we_n_o(we_n),
        .addr_o(maddr));
    psbc_top DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rq),
        .avs_waitrequest_o(wq), .mem_clk_i(mclk), .ce_n_i(ce_n), .adv_n_i(adv_n), .we_n_i(we_n),
        .addr_i(maddr), .refresh_busy_i(rfsh), .wait_o(wt), .burst_addr_o(baddr), .rd_valid_o(rv),
        .wr_valid_o(wv), .sync_write_o(sw), .async_acc_o(aa));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        adr <= a;
        rd <= ~w;
        wr <= w;
        wd <= d;
        // Waitrequest is read mid-cycle; the transfer completes at the following rising edge
        do @(negedge ref_clk_i); while (wq !== 1'b0);
        @(posedge ref_clk_i);
        q = rq;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task cfg(input logic [31:0] d);
        logic [31:0] q;
        bus(4'h0, 1'b1, d, q);
        bus(4'h0, 1'b0, 32'h0, q);
        chk("config", q, d);
    endtask : cfg
    // Counts link rises to first data, then follows five burst words
    task burst(input logic [22:0] a, input logic w, input int lat, input logic [22:0] m, input logic wexp);
        int r0;
        int k;
        logic ws;
        r0 = rises;
        k = 0;
        ws = 1'b0;
        fork
            M.cmd(a, w, 1'b1);
        join_none
        while (k < 5) begin
            @(posedge ref_clk_i);
            if (k == 0) ws |= (wt === 1'b1);
            if ((w ? wv : rv) === 1'b1) begin
                if (k == 0) chk("latency", 32'(rises - r0), 32'(lat + 1));
                chk("address", {9'h0, baddr}, {9'h0, (a & ~m) | (23'(a + k) & m)});
                k++;
            end
        end
        chk("wait", 32'(ws), 32'(wexp));
        M.stop();
    endtask : burst
    task acc(input logic w);
        M.cmd(23'h10, w, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        if (w) chk("sync write", 32'(sw), 32'h0);
        else chk("async", 32'(aa), 32'h1);
        M.stop();
    endtask : acc
    task tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        logic [31:0] q;
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        bus(4'h0, 1'b0, 32'h0, q);
        chk("reset config", q, 32'h9d1f);
        bus(4'hc, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        acc(1'b0);
        cfg(32'h5502);
        burst(23'd6, 1'b0, 2, 23'h7, 1'b0);
        cfg(32'h5501);
        burst(23'd30, 1'b0, 2, 23'h3, 1'b0);
        burst(23'd30, 1'b1, 2, 23'h3, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        chk("sync write", 32'(sw), 32'h1);
        acc(1'b1);
        cfg(32'h1d0f);
        rfsh <= 1'b1;
        burst(23'd120, 1'b0, 7, 23'h7fffff, 1'b1);
        burst(23'd120, 1'b1, 3, 23'h7fffff, 1'b0);
        tally_and_finish();
    end
endmodule : psram_burst_bus_config_tb
